// file: verilog/phy_regs_defs.svh
`ifndef PHY_REGS_DEFS_SVH
`define PHY_REGS_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets on the management interface
// ----------------------------------------------------------------------
`define BASIC_STATUS_OFS 5'h01
`define PHY_ID_HIGH_OFS 5'h02
`define PHY_ID_LOW_OFS 5'h03
`define ADVERT_OFS 5'h04

// ----------------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------------
`define BASIC_STATUS_RESET 16'h7849
`define ADVERT_RESET 16'h01e1
`define ADVERT_WMASK 16'hadff

// ----------------------------------------------------------------------
// live field positions in the basic status word
// ----------------------------------------------------------------------
`define ST_AN_DONE_BIT 5
`define ST_RFAULT_BIT 4
`define ST_LINK_BIT 2
`define ST_JABBER_BIT 1

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define PREAMBLE_LEN 6'd32
`define HDR_LAST 4'd12
`define DATA_LAST 4'd15
`define OP_READ 2'b10
`define OP_WRITE 2'b01

`endif

// file: verilog/phy_regs_pkg.sv
package phy_regs_pkg;

   // management frame sequencer
   typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_TA, ST_DATA} mgmt_state_t;

   // live state of the transceiver, same clock as the bank
   typedef struct packed {
      logic autoneg_done;
      logic link_up;
      logic remote_fault_evt;
      logic jabber_evt;
   } phy_status_t;

   // whole state of the bank
   typedef struct packed {
      mgmt_state_t fsm;
      logic [5:0] pre_cnt;
      logic pre_skip;
      logic [11:0] hdr;
      logic [3:0] bit_cnt;
      logic is_read;
      logic hit;
      logic [4:0] reg_addr;
      logic [15:0] shift;
      logic rf_latch;
      logic jab_latch;
      logic [15:0] advert;
      logic mdio_out;
      logic mdio_oe_n;
      logic mdc_prev;
   } bank_state_t;

endpackage

// file: verilog/sync2.sv
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser for pins from outside the clock domain
module sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // pin side and clock side
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   // first stage feeds only the second one
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule

`default_nettype wire

// file: verilog/phy_status_id_advert_regs.sv
// Functional notes
// R1: basic status at 0x1 resets to 0x7849
// R2: status bit 15 always reads zero
// R3: status bits 14 to 11 read one
// R4: bit 6 one; preamble needed once only
// R5: host gives idle gap and one-bit
// R6: bit 5 shows negotiation complete
// R7: bit 4 latches fault, clears on read
// R8: bit 3 reads one, negotiation able
// R9: bit 2 shows valid link
// R10: bit 1 shows jabber detected
// R11: bit 0 reads one, extended registers
// R12: id high at 0x2 fixed value
// R13: id low holds oui, model, revision
// R14: advert at 0x4 resets 0x1e1, bit15 rw
// R15: software never sets advert bit 13
// R16: advert bit 11 rw asymmetric pause
// R17: advert bits 4-0 selector resets 0x1
// R18: reserved bits read zero, ignore writes

// limitation: mdc must stay high and low for at least two core clocks,
// or an edge is lost in the synchroniser
`timescale 1ns/100ps
`default_nettype none
`include "phy_regs_defs.svh"

module phy_status_id_advert_regs #(
   parameter logic [15:0] OUI_HIGH = 16'h5a5a, // arbitrary value
   parameter logic [5:0] OUI_LOW = 6'h15, // arbitrary value
   parameter logic [5:0] MODEL_NUM = 6'h2b, // arbitrary value
   parameter logic [3:0] REVISION = 4'h3 // arbitrary value
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // management pins
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_n,
   // station address straps
   input wire logic [4:0] phy_addr,
   // transceiver state
   input wire phy_regs_pkg::phy_status_t phy_status,
   // advertisement towards negotiation logic
   output logic [15:0] advert
);
   import phy_regs_pkg::*;

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   logic mdc_s;
   logic mdio_s;
   logic [4:0] addr_s;

   // pins share one synchroniser so a data bit and its mdc edge stay aligned
   sync2 #(
      .W(7)
   ) u_sync (
      .clock(clock),
      .rst(rst),
      .d({mdc, mdio_in, phy_addr}),
      .q({mdc_s, mdio_s, addr_s})
   );

   // ----------------------------------------------------------------------
   // frame decode
   // ----------------------------------------------------------------------
   // whole state in one register; the next value is built in one process
   bank_state_t s_r;
   bank_state_t s_nxt;
   logic rise;
   logic [12:0] frame;
   logic [15:0] wdata;
   logic hdr_end;
   logic op_ok;
   logic rd_hit_end;
   logic status_rd;
   logic data_end;
   logic wr_commit;
   logic ta_bad;
   logic [15:0] rd_word;

   // mdc edge seen on the synchronised copy, third stage holds history
   assign rise = mdc_s & ~s_r.mdc_prev;
   assign frame = {s_r.hdr, mdio_s};
   assign wdata = {s_r.shift[14:0], mdio_s};
   assign hdr_end = rise && s_r.fsm == ST_HDR && s_r.bit_cnt == `HDR_LAST;
   assign op_ok = frame[11:10] == `OP_READ || frame[11:10] == `OP_WRITE;
   assign rd_hit_end = hdr_end && frame[12] && frame[11:10] == `OP_READ
      && frame[9:5] == addr_s;
   assign status_rd = rd_hit_end && frame[4:0] == `BASIC_STATUS_OFS;
   assign data_end = rise && s_r.fsm == ST_DATA && s_r.bit_cnt == `DATA_LAST;
   assign wr_commit = data_end && !s_r.is_read && s_r.hit;
   // a write turnaround must be one then zero; a read one is not ours
   assign ta_bad = rise && s_r.fsm == ST_TA && !s_r.is_read
      && (mdio_s != (s_r.bit_cnt == 4'd0));

   // ----------------------------------------------------------------------
   // read multiplexer
   // ----------------------------------------------------------------------
   // unmapped offsets read as zero
   always_comb begin
      rd_word = 16'h0000;
      unique case (frame[4:0])
         `BASIC_STATUS_OFS: begin
            rd_word = `BASIC_STATUS_RESET; // R1 R2 R3 R4 R8 R11 R18
            rd_word[`ST_AN_DONE_BIT] = phy_status.autoneg_done; // R6
            rd_word[`ST_RFAULT_BIT] = s_r.rf_latch; // R7
            rd_word[`ST_LINK_BIT] = phy_status.link_up; // R9
            rd_word[`ST_JABBER_BIT] = s_r.jab_latch; // R10
         end
         `PHY_ID_HIGH_OFS: begin
            rd_word = OUI_HIGH; // R12
         end
         `PHY_ID_LOW_OFS: begin
            rd_word = {OUI_LOW, MODEL_NUM, REVISION}; // R13
         end
         `ADVERT_OFS: begin
            rd_word = s_r.advert;
         end
         default: begin
            rd_word = 16'h0000;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.mdc_prev = mdc_s;
      // an event in the clearing cycle still sets the latch
      s_nxt.rf_latch = (status_rd ? 1'b0 : s_r.rf_latch)
         | phy_status.remote_fault_evt; // R7
      s_nxt.jab_latch = (status_rd ? 1'b0 : s_r.jab_latch)
         | phy_status.jabber_evt; // R10
      if (rise) begin
         unique case (s_r.fsm)
            ST_IDLE: begin
               if (mdio_s) begin
                  if (s_r.pre_cnt != `PREAMBLE_LEN) begin
                     s_nxt.pre_cnt = s_r.pre_cnt + 6'd1;
                  end
               end else begin
                  s_nxt.pre_cnt = 6'd0;
                  // suppressed preamble still needs one idle one-bit
                  if (s_r.pre_cnt == `PREAMBLE_LEN
                        || (s_r.pre_skip && s_r.pre_cnt != 6'd0)) begin // R4 R5
                     s_nxt.fsm = ST_HDR;
                     s_nxt.bit_cnt = 4'd0;
                  end
               end
            end
            ST_HDR: begin
               s_nxt.hdr = frame[11:0];
               s_nxt.bit_cnt = s_r.bit_cnt + 4'd1;
               if (s_r.bit_cnt == `HDR_LAST) begin
                  s_nxt.bit_cnt = 4'd0;
                  s_nxt.is_read = frame[11:10] == `OP_READ;
                  s_nxt.hit = frame[9:5] == addr_s;
                  s_nxt.reg_addr = frame[4:0];
                  // read data is a snapshot taken here, so a slow host sees one word
                  s_nxt.shift = rd_word;
                  if (!frame[12]) begin
                     s_nxt.fsm = ST_IDLE;
                  end else if (!op_ok) begin
                     s_nxt.fsm = ST_IDLE;
                     s_nxt.pre_skip = 1'b0; // R4
                  end else begin
                     s_nxt.fsm = ST_TA;
                  end
               end
            end
            ST_TA: begin
               s_nxt.bit_cnt = s_r.bit_cnt + 4'd1;
               if (ta_bad) begin
                  s_nxt.fsm = ST_IDLE;
                  s_nxt.pre_skip = 1'b0; // R4
               end else if (s_r.bit_cnt == 4'd0) begin
                  // second turnaround bit is driven low by us
                  if (s_r.is_read && s_r.hit) begin
                     s_nxt.mdio_out = 1'b0;
                     s_nxt.mdio_oe_n = 1'b0;
                  end
               end else begin
                  s_nxt.fsm = ST_DATA;
                  s_nxt.bit_cnt = 4'd0;
                  if (s_r.is_read && s_r.hit) begin
                     s_nxt.mdio_out = s_r.shift[15];
                     s_nxt.shift = {s_r.shift[14:0], 1'b0};
                  end
               end
            end
            ST_DATA: begin
               s_nxt.bit_cnt = s_r.bit_cnt + 4'd1;
               if (s_r.is_read) begin
                  if (s_r.hit) begin
                     s_nxt.mdio_out = s_r.shift[15];
                     s_nxt.shift = {s_r.shift[14:0], 1'b0};
                  end
               end else begin
                  // write data enters msb first and lands only at the last bit
                  s_nxt.shift = wdata;
               end
               if (s_r.bit_cnt == `DATA_LAST) begin
                  s_nxt.fsm = ST_IDLE;
                  s_nxt.pre_cnt = 6'd0;
                  s_nxt.mdio_oe_n = 1'b1;
                  s_nxt.mdio_out = 1'b1;
                  if (s_r.hit) begin
                     s_nxt.pre_skip = 1'b1; // R4
                  end
                  // identifier and status writes fall away
                  // bit 13 stays writable; keeping it clear is up to software
                  if (wr_commit && s_r.reg_addr == `ADVERT_OFS) begin
                     s_nxt.advert = wdata & `ADVERT_WMASK; // R14 R16 R17 R18
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_r <= '0;
         s_r.fsm <= ST_IDLE;
         s_r.advert <= `ADVERT_RESET; // R14 R17
         s_r.mdio_out <= 1'b1;
         s_r.mdio_oe_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs come straight from the state register
   assign mdio_out = s_r.mdio_out;
   assign mdio_oe_n = s_r.mdio_oe_n;
   assign advert = s_r.advert;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   // all checks run on the core clock and rest while reset is high
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence status_hdr;
      status_rd;
   endsequence

   sequence adv_write;
      wr_commit && s_r.reg_addr == `ADVERT_OFS;
   endsequence

   chk_no_t4: assert property (status_hdr |=> s_r.shift[15] == 1'b0) // R2
      else $error("t4 capability not zero");
   chk_fixed_caps: assert property (status_hdr |=> s_r.shift[14:11] == 4'hf) // R3
      else $error("speed capabilities not all one");
   chk_status_resv: assert property (status_hdr |=> s_r.shift[10:7] == 4'h0) // R18
      else $error("status reserved bits not zero");
   chk_skip_cap: assert property (status_hdr |=> s_r.shift[6]) // R4
      else $error("preamble skip capability missing");
   chk_an_bit: assert property (status_hdr |=> // R6
         s_r.shift[5] == $past(phy_status.autoneg_done))
      else $error("negotiation complete bit wrong");
   chk_an_ability: assert property (status_hdr |=> s_r.shift[3]) // R8
      else $error("negotiation ability bit missing");
   chk_link_bit: assert property (status_hdr |=> // R9
         s_r.shift[2] == $past(phy_status.link_up))
      else $error("link bit wrong");
   chk_ext_cap: assert property (status_hdr |=> s_r.shift[0]) // R11
      else $error("extended capability bit missing");
   chk_rf_set: assert property (phy_status.remote_fault_evt |=> s_r.rf_latch) // R7
      else $error("remote fault not latched");
   chk_rf_clear: assert property (status_hdr ##0 !phy_status.remote_fault_evt // R7
         |=> !s_r.rf_latch)
      else $error("remote fault not cleared by read");
   chk_jab_set: assert property (phy_status.jabber_evt |=> s_r.jab_latch) // R10
      else $error("jabber not latched");
   chk_id_high: assert property (rd_hit_end && frame[4:0] == `PHY_ID_HIGH_OFS // R12
         |=> s_r.shift == OUI_HIGH)
      else $error("identifier high wrong");
   chk_id_low: assert property (rd_hit_end && frame[4:0] == `PHY_ID_LOW_OFS // R13
         |=> s_r.shift == {OUI_LOW, MODEL_NUM, REVISION})
      else $error("identifier low wrong");
   chk_adv_reset: assert property ($fell(rst) |-> s_r.advert == `ADVERT_RESET) // R14
      else $error("advert reset value wrong");
   chk_adv_write: assert property (adv_write |=> // R16
         s_r.advert[15:10] == ($past(wdata[15:10]) & 6'b101011))
      else $error("advert upper bits not written");
   chk_adv_sel: assert property (adv_write |=> // R17
         s_r.advert[4:0] == $past(wdata[4:0]))
      else $error("selector field not written");
   chk_adv_resv: assert property (!s_r.advert[14] && !s_r.advert[12]) // R18
      else $error("advert reserved bits set");
   chk_op_drop: assert property (hdr_end && frame[12] && !op_ok |=> !s_r.pre_skip) // R4
      else $error("preamble skip kept after bad opcode");

   // ----------------------------------------------------------------------
   // data line, frame end, jabber clear and advert hold checks
   // ----------------------------------------------------------------------
   // a read aimed at us answers with a zero in the second turnaround bit
   sequence rd_turn;
      rise && s_r.fsm == ST_TA && s_r.bit_cnt == 4'd0 && s_r.is_read && s_r.hit;
   endsequence

   // one data bit of a read aimed at us, the last one excluded
   sequence rd_bit;
      rise && s_r.fsm == ST_DATA && s_r.is_read && s_r.hit && s_r.bit_cnt != `DATA_LAST;
   endsequence

   // the last data bit of any frame, ours or another station's
   sequence frame_done;
      data_end;
   endsequence

   // a frame for another station reaching its turnaround
   sequence miss_turn;
      rise && s_r.fsm == ST_TA && !s_r.hit;
   endsequence

   chk_turn_drive: assert property (rd_turn |=> !s_r.mdio_oe_n && !s_r.mdio_out) // R1
      else $error("turnaround zero not driven");
   chk_rd_bit: assert property (rd_bit |=> s_r.mdio_out == $past(s_r.shift[15])) // R1
      else $error("read data bit out of order");
   chk_line_free: assert property (frame_done |=> s_r.mdio_oe_n && s_r.mdio_out) // R4
      else $error("data line not released after frame");
   chk_miss_quiet: assert property (miss_turn |=> s_r.mdio_oe_n) // R4
      else $error("line driven for another station");
   chk_skip_earn: assert property (frame_done ##0 s_r.hit |=> s_r.pre_skip) // R4
      else $error("preamble skip not earned");
   chk_ta_drop: assert property (ta_bad |=> !s_r.pre_skip && s_r.fsm == ST_IDLE) // R4
      else $error("preamble skip kept after bad turnaround");
   chk_jab_clear: assert property (status_hdr ##0 !phy_status.jabber_evt // R10
         |=> !s_r.jab_latch)
      else $error("jabber not cleared by read");
   chk_adv_hold: assert property (!adv_write |=> $stable(s_r.advert)) // R18
      else $error("advert changed without a write");

endmodule

`default_nettype wire

// file: testbench/mgmt_host.sv
`timescale 1ns/100ps
`default_nettype none

// station management controller: paces mdc from the core clock, 16 core clocks per bit
module mgmt_host (
   // core clock used for pacing
   input wire logic clock,
   // management pins
   output logic mdc,
   output logic host_d,
   output logic host_oe_n,
   input wire logic mdio
);
   // turnaround bits of a write; a scenario may spoil them on purpose
   logic [1:0] ta_bits = 2'b10;

   initial begin
      mdc = 1'b0;
      host_d = 1'b1;
      host_oe_n = 1'b1;
   end

   // one bit: change data after mdc fall, sample the line at the rise
   task automatic bit_cyc(input logic drive, input logic b, output logic s);
      host_oe_n = !drive;
      host_d = b;
      repeat (8) @(negedge clock);
      mdc = 1'b1;
      s = mdio;
      repeat (8) @(negedge clock);
      mdc = 1'b0;
   endtask

   // idle gap with the line released and mdc still, then one rise with mdio high
   task automatic gap();
      logic s;
      host_oe_n = 1'b1;
      repeat (64) @(negedge clock);
      bit_cyc(1'b1, 1'b1, s);
   endtask

   // whole frame; the line is released in turnaround and data unless writing
   task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] pa,
                        input logic [4:0] ra, input logic [15:0] wd,
                        output logic [15:0] rd);
      logic [13:0] hdr;
      logic s;
      logic wr;
      hdr = {2'b01, op, pa, ra};
      wr = (op == 2'b01);
      for (int i = 0; i < pre; i++) bit_cyc(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
      bit_cyc(wr, ta_bits[1], s);
      bit_cyc(wr, ta_bits[0], s);
      for (int i = 15; i >= 0; i--) begin
         bit_cyc(wr, wd[i], s);
         rd[i] = s;
      end
   endtask
endmodule
`default_nettype wire

// file: testbench/phy_status_id_advert_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none

module phy_status_id_advert_regs_tb;
   import phy_regs_pkg::*;
   localparam logic [15:0] ID_HI = 16'h3c3c; // arbitrary value
   localparam logic [5:0] ID_OUI = 6'h09; // arbitrary value
   localparam logic [5:0] ID_MODEL = 6'h12; // arbitrary value
   localparam logic [3:0] ID_REV = 4'h6; // arbitrary value
   localparam logic [4:0] MY_ADDR = 5'h0a;

   logic clock = 1'b0;
   logic rst = 1'b1;
   logic mdc, host_d, host_oe_n, mdio, mdio_out, mdio_oe_n;
   phy_status_t phy_status = '0;
   logic [15:0] advert, v;
   int err_count = 0;
   int check_count = 0;
   int cyc_count = 0;

   // ---------------------------------------------
   // clock, pins and instances
   // ---------------------------------------------
   always #4 clock = !clock;
   // pull-up on the shared line when nobody drives
   assign mdio = !mdio_oe_n ? mdio_out : (!host_oe_n ? host_d : 1'b1);

   phy_status_id_advert_regs #(.OUI_HIGH(ID_HI), .OUI_LOW(ID_OUI), .MODEL_NUM(ID_MODEL),
                               .REVISION(ID_REV)) i_phy_status_id_advert_regs (
      .clock(clock), .rst(rst), .mdc(mdc), .mdio_in(mdio), .mdio_out(mdio_out),
      .mdio_oe_n(mdio_oe_n), .phy_addr(MY_ADDR), .phy_status(phy_status), .advert(advert));

   mgmt_host i_mgmt_host (.clock(clock), .mdc(mdc), .host_d(host_d),
                          .host_oe_n(host_oe_n), .mdio(mdio));

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // gap first, so a short preamble is legal whenever skip is earned
   task automatic xfer(input int pre, input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
      i_mgmt_host.gap();
      i_mgmt_host.frame(pre, op, pa, ra, wd, rd);
   endtask

   task automatic rd_reg(input logic [4:0] ra, output logic [15:0] rd);
      xfer(32, 2'b10, MY_ADDR, ra, 16'h0000, rd);
   endtask

   task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
      logic [15:0] d;
      xfer(32, 2'b01, MY_ADDR, ra, wd, d);
   endtask

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_reset();
      rd_reg(5'h01, v);
      check_word("status after reset", 16'h7849, v);
      rd_reg(5'h04, v);
      check_word("advert after reset", 16'h01e1, v);
      check_word("advert port", 16'h01e1, advert);
   endtask

   task automatic t_ident();
      rd_reg(5'h02, v);
      check_word("id high", ID_HI, v);
      wr_reg(5'h02, 16'h0000);
      rd_reg(5'h02, v);
      check_word("id high after write", ID_HI, v);
      rd_reg(5'h03, v);
      check_word("id low", {ID_OUI, ID_MODEL, ID_REV}, v);
   endtask

   task automatic t_live();
      @(negedge clock);
      phy_status.autoneg_done = 1'b1;
      phy_status.link_up = 1'b1;
      rd_reg(5'h01, v);
      check_word("status live up", 16'h786d, v);
      @(negedge clock);
      phy_status.autoneg_done = 1'b0;
      phy_status.link_up = 1'b0;
      rd_reg(5'h01, v);
      check_word("status live down", 16'h7849, v);
   endtask

   task automatic t_latch();
      @(negedge clock);
      phy_status.remote_fault_evt = 1'b1;
      phy_status.jabber_evt = 1'b1;
      @(negedge clock);
      phy_status.remote_fault_evt = 1'b0;
      phy_status.jabber_evt = 1'b0;
      rd_reg(5'h01, v);
      check_word("status latched", 16'h785b, v);
      rd_reg(5'h01, v);
      check_word("status cleared by read", 16'h7849, v);
   endtask

   task automatic t_advert();
      wr_reg(5'h04, 16'hdfff);
      rd_reg(5'h04, v);
      check_word("advert all set", 16'h8dff, v);
      check_word("advert port set", 16'h8dff, advert);
      wr_reg(5'h04, 16'h0000);
      rd_reg(5'h04, v);
      check_word("advert cleared", 16'h0000, v);
      wr_reg(5'h01, 16'hffff);
      rd_reg(5'h01, v);
      check_word("status after write", 16'h7849, v);
   endtask

   // skip earned, lost by a bad opcode, earned again by a full preamble
   task automatic t_skip();
      rd_reg(5'h01, v);
      xfer(0, 2'b10, MY_ADDR, 5'h01, 16'h0000, v);
      check_word("short preamble read", 16'h7849, v);
      xfer(0, 2'b00, MY_ADDR, 5'h01, 16'h0000, v);
      xfer(0, 2'b10, MY_ADDR, 5'h01, 16'h0000, v);
      check_word("short read after bad op", 16'hffff, v);
      rd_reg(5'h01, v);
      check_word("full read after bad op", 16'h7849, v);
      i_mgmt_host.ta_bits = 2'b11;
      xfer(0, 2'b01, MY_ADDR, 5'h04, 16'h8000, v);
      i_mgmt_host.ta_bits = 2'b10;
      xfer(0, 2'b10, MY_ADDR, 5'h04, 16'h0000, v);
      check_word("short read after bad ta", 16'hffff, v);
      rd_reg(5'h04, v);
      check_word("advert kept after bad ta", 16'h0000, v);
   endtask

   // another station's address is left alone; unmapped offsets read zero
   task automatic t_refuse();
      xfer(32, 2'b10, 5'h0b, 5'h01, 16'h0000, v);
      check_word("other station read", 16'hffff, v);
      rd_reg(5'h05, v);
      check_word("unmapped read", 16'h0000, v);
   endtask

   // ---------------------------------------------
   // closing and main sequence
   // ---------------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // hang guard, about twice the expected run
   always @(posedge clock) begin
      cyc_count++;
      if (cyc_count == 50000) begin
         err_count++;
         results();
      end
   end

   initial begin
      repeat (8) @(negedge clock);
      rst = 1'b0;
      repeat (4) @(negedge clock);
      t_reset();
      t_ident();
      t_live();
      t_latch();
      t_advert();
      t_skip();
      t_refuse();
      results();
   end
endmodule
`default_nettype wire
